/* File: vfid_defs.svh */
// Constants for the vector feature identification register block
`ifndef VFID_DEFS_SVH
`define VFID_DEFS_SVH

// Field positions (low bit of each 4-bit field)
`define VFID_DMM_LSB 56
`define VFID_SMM_LSB 52
`define VFID_BMM_LSB 44
`define VFID_SM4_LSB 40
`define VFID_SHA3_LSB 32
`define VFID_NWBF_LSB 24
`define VFID_BF_LSB 20
`define VFID_BPERM_LSB 16
`define VFID_AES_LSB 4
`define VFID_VER_LSB 0

// Field values
`define VFID_DMM_VAL 4'h0
`define VFID_SMM_VAL 4'h0
`define VFID_BMM_VAL 4'h1
`define VFID_SM4_ON 4'h1
`define VFID_SHA3_ON 4'h1
`define VFID_NWBF_VAL 4'h0
`define VFID_BF_VAL 4'h1
`define VFID_BPERM_VAL 4'h1
`define VFID_AES_ON 4'h2
`define VFID_VER_VAL 4'h1
`define VFID_FIELD_OFF 4'h0

// Selecting encoding of the system-register read
`define VFID_OP0 2'h3
`define VFID_OP1 3'h0
`define VFID_CRN 4'h0
`define VFID_CRM 4'h4
`define VFID_OP2 3'h4

// Trap class for a refused read
`define VFID_TRAP_CLASS 6'h18

`endif

/* File: vfid_pkg.sv */
// Types for the vector feature identification register block
package vfid_pkg;

  // Privilege levels, encoded as the level number
  typedef enum logic [1:0] {
    VFID_LVL_USER = 2'h0,
    VFID_LVL_KERNEL = 2'h1,
    VFID_LVL_HYP = 2'h2,
    VFID_LVL_MON = 2'h3
  } vfid_level_type;

  // Read answer states, one-hot
  typedef enum logic [2:0] {
    VFID_ST_IDLE = 3'h1,
    VFID_ST_DATA = 3'h2,
    VFID_ST_TRAP = 3'h4
  } vfid_state_type;

endpackage

/* File: vfid_reg.sv */
// Vector feature identification register with privilege-checked read port
`timescale 1ns/1ps
`include "vfid_defs.svh"

// Function
// - Double matrix multiply field reads zero
// - Single matrix multiply field reads zero
// - Byte matrix multiply field reads one
// - SM4 field one when cipher and SM group enabled
// - SHA-3 field one when cipher enabled
// - Non-widening bfloat field reads zero
// - Bfloat field reads one
// - Bit permute field reads one
// - AES field two when cipher enabled
// - Vector version field reads one
// - Reserved bit ranges read zero
// - Selected by fixed system-register encoding
// - User read traps, hypervisor or kernel
// - Kernel read traps to hypervisor when hypervisor enabled and id trap set
// - Hypervisor and monitor reads always succeed
// - Matrix-only core runs streaming vector only
// - Cipher enabled: build parameter, disable low
module vfid_reg
  import vfid_pkg::*;
#(
  parameter bit CIPHER_BUILD_PARAMETER = 1'b1,
  parameter bit SM_GROUP_ENABLE = 1'b1,
  parameter bit MATRIX_EXTENSION_FEATURE = 1'b1,
  parameter bit VECTOR_EXTENSION_FEATURE = 1'b1
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Configuration straps
  input wire logic cipher_disable_input_in,
  // Privilege context
  input wire logic [1:0] current_privilege_level_in,
  input wire logic hyp_enabled_in,
  input wire logic hyp_trap_general_bit_in,
  input wire logic hyp_id_group3_trap_bit_in,
  // Streaming mode state
  input wire logic streaming_mode_in,
  // System-register access request
  input wire logic sysreg_req_in,
  input wire logic sysreg_write_in,
  input wire logic [1:0] op0_in,
  input wire logic [2:0] op1_in,
  input wire logic [3:0] crn_in,
  input wire logic [3:0] crm_in,
  input wire logic [2:0] op2_in,
  // Read answer, vector instruction legality and register image
  input wire logic vector_instr_in,
  output logic sysreg_ack_out,
  output logic [63:0] sysreg_rdata_out,
  output logic sysreg_trap_out,
  output logic [1:0] trap_level_out,
  output logic [5:0] trap_class_out,
  output logic vector_instr_legal_out,
  output logic [63:0] vector_feature_id_out
);

  // The register makes no sense unless some vector capability exists
  initial begin
    if (!MATRIX_EXTENSION_FEATURE && !VECTOR_EXTENSION_FEATURE) begin
      $error("vfid_reg: needs the matrix or vector extension");
    end
  end

  vfid_state_type state_reg;
  vfid_state_type state_next;
  logic strap_taken_reg;
  logic cipher_on_reg;
  logic [63:0] vector_feature_id_reg;
  logic [63:0] rdata_reg;
  logic [1:0] trap_level_reg;
  logic [1:0] trap_level_next;
  logic trap_next;
  logic hit;

  // Assemble the identification value from the cipher enable
  function automatic logic [63:0] vfid_value(input logic cipher_on);
    logic [63:0] v;
    v = 64'h0;
    v[`VFID_DMM_LSB +: 4] = `VFID_DMM_VAL;
    v[`VFID_SMM_LSB +: 4] = `VFID_SMM_VAL;
    v[`VFID_BMM_LSB +: 4] = `VFID_BMM_VAL;
    v[`VFID_SM4_LSB +: 4] = (cipher_on && SM_GROUP_ENABLE) ? `VFID_SM4_ON
                                                          : `VFID_FIELD_OFF;
    v[`VFID_SHA3_LSB +: 4] = cipher_on ? `VFID_SHA3_ON : `VFID_FIELD_OFF;
    v[`VFID_NWBF_LSB +: 4] = `VFID_NWBF_VAL;
    v[`VFID_BF_LSB +: 4] = `VFID_BF_VAL;
    v[`VFID_BPERM_LSB +: 4] = `VFID_BPERM_VAL;
    v[`VFID_AES_LSB +: 4] = cipher_on ? `VFID_AES_ON : `VFID_FIELD_OFF;
    v[`VFID_VER_LSB +: 4] = `VFID_VER_VAL;
    return v;
  endfunction

  // Strap capture: async reset may only load constants, so the disable
  // input is sampled on the first clock edge after release and held
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      strap_taken_reg <= 1'b0;
      cipher_on_reg <= 1'b0;
    end else if (!strap_taken_reg) begin
      strap_taken_reg <= 1'b1;
      cipher_on_reg <= CIPHER_BUILD_PARAMETER && !cipher_disable_input_in;
    end
  end

  // Register image; no write path reaches it
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      vector_feature_id_reg <= vfid_value(1'b0);
    end else begin
      vector_feature_id_reg <= vfid_value(cipher_on_reg);
    end
  end

  // Encoding match; writes never hit, so they neither store nor answer data
  assign hit = sysreg_req_in && !sysreg_write_in
               && op0_in == `VFID_OP0 && op1_in == `VFID_OP1
               && crn_in == `VFID_CRN && crm_in == `VFID_CRM
               && op2_in == `VFID_OP2;

  // Privilege check decides between data and trap
  always_comb begin
    trap_next = 1'b0;
    trap_level_next = VFID_LVL_KERNEL;
    case (current_privilege_level_in)
      VFID_LVL_USER: begin
        trap_next = 1'b1;
        trap_level_next = (hyp_enabled_in && hyp_trap_general_bit_in) ? VFID_LVL_HYP
                                                                      : VFID_LVL_KERNEL;
      end
      VFID_LVL_KERNEL: begin
        trap_next = hyp_enabled_in && hyp_id_group3_trap_bit_in;
        trap_level_next = VFID_LVL_HYP;
      end
      default: begin
        trap_next = 1'b0;
      end
    endcase
  end

  // Answer state: one cycle of data or trap after each hit once the strap is taken
  always_comb begin
    case (state_reg)
      VFID_ST_IDLE, VFID_ST_DATA, VFID_ST_TRAP: begin
        if (hit && strap_taken_reg) begin
          state_next = trap_next ? VFID_ST_TRAP : VFID_ST_DATA;
        end else begin
          state_next = VFID_ST_IDLE;
        end
      end
      default: begin
        state_next = VFID_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= VFID_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Answer data; a trapped read returns zero so nothing leaks
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_reg <= 64'h0;
      trap_level_reg <= VFID_LVL_KERNEL;
    end else begin
      if (hit && strap_taken_reg && !trap_next) begin
        // Built from the taken strap, not the image, so a read on the second
        // edge after reset already carries the final value
        rdata_reg <= vfid_value(cipher_on_reg);
      end else begin
        rdata_reg <= 64'h0;
      end
      trap_level_reg <= trap_level_next;
    end
  end

  assign sysreg_ack_out = state_reg != VFID_ST_IDLE;
  assign sysreg_trap_out = state_reg == VFID_ST_TRAP;
  assign sysreg_rdata_out = rdata_reg;
  assign trap_level_out = trap_level_reg;
  assign trap_class_out = (state_reg == VFID_ST_TRAP) ? `VFID_TRAP_CLASS : 6'h00;
  assign vector_feature_id_out = vector_feature_id_reg;

  // Without the vector extension only streaming-mode vector work is legal;
  // the caller still filters which instructions are streaming-legal
  assign vector_instr_legal_out = vector_instr_in
                                  && (VECTOR_EXTENSION_FEATURE || streaming_mode_in);

endmodule

/* File: vfid_reg_properties.sv */
// Port-level assertions for the vector feature id register block
`timescale 1ns/1ps
module vfid_reg_properties (
  // Clock, reset and request
  input wire logic sys_clk_in, rst_in, sysreg_req_in, sysreg_write_in,
  input wire logic hyp_enabled_in, hyp_trap_general_bit_in, hyp_id_group3_trap_bit_in,
  input wire logic [1:0] current_privilege_level_in, op0_in,
  input wire logic [2:0] op1_in, op2_in,
  input wire logic [3:0] crn_in, crm_in,
  // Answer
  input wire logic sysreg_ack_out, sysreg_trap_out,
  input wire logic [1:0] trap_level_out,
  input wire logic [5:0] trap_class_out,
  input wire logic [63:0] sysreg_rdata_out, vector_feature_id_out);
  logic [1:0] up_reg;
  logic hit;
  logic [1:0] lvl;
  // Edges since reset; the first edge only takes the strap, so requests there are ignored
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) up_reg <= 2'h0;
    else if (up_reg != 2'h3) up_reg <= up_reg + 2'h1;
  end
  // A request that must be answered
  assign lvl = current_privilege_level_in;
  assign hit = sysreg_req_in && !sysreg_write_in && up_reg != 2'h0 && op0_in == 2'h3
    && op1_in == 3'h0 && crn_in == 4'h0 && crm_in == 4'h4 && op2_in == 3'h4;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  a_hit_answers:
    assert property (hit |=> sysreg_ack_out) else $error("read not answered");
  a_refused_silent:
    assert property (!hit |=> !sysreg_ack_out && !sysreg_trap_out) else $error("stray answer");
  a_user_traps:
    assert property (hit && lvl == 2'h0 |=> sysreg_trap_out && trap_level_out ==
      ($past(hyp_enabled_in && hyp_trap_general_bit_in) ? 2'h2 : 2'h1)) else $error("user read");
  a_kernel_trap:
    assert property (hit && lvl == 2'h1 |=> sysreg_trap_out == $past(hyp_enabled_in &&
      hyp_id_group3_trap_bit_in) && (!sysreg_trap_out || trap_level_out == 2'h2))
      else $error("kernel read");
  a_high_read:
    assert property (hit && lvl[1] |=> sysreg_ack_out && sysreg_rdata_out == vector_feature_id_out)
      else $error("high level read");
  a_trap_class:
    assert property (trap_class_out == (sysreg_trap_out ? 6'h18 : 6'h00)) else $error("class");
  a_fixed_fields:
    assert property ((vector_feature_id_out & 64'hffff_f0f0_ffff_ff0f) == 64'h0000_1000_0011_0001)
      else $error("fixed field wrong");
  a_image_stable:
    assert property (up_reg == 2'h3 |-> $stable(vector_feature_id_out)) else $error("image moved");
  // Main scenarios reached
  c_user: cover property (hit && lvl == 2'h0);
  c_kernel: cover property (hit && lvl == 2'h1);
  c_mon: cover property (hit && lvl == 2'h3);
endmodule
bind vfid_reg vfid_reg_properties chk_u (.*);

/* File: tb_vfid_reg.sv */
// Self-checking bench for the vector feature id register block
`timescale 1ns/1ps
module tb_vfid_reg;
  import vfid_pkg::*;
  logic sys_clk_in = 0, rst_in = 1, dis = 0, req = 0, wr = 0, hen = 0, tge = 0, tid = 0;
  logic sm = 0, vi = 0, ack, trap, legal;
  logic [1:0] lvl = 2'h0, tl;
  logic [15:0] enc = 16'hc024; // op0 3, op1 0, crn 0, crm 4, op2 4
  logic [63:0] rdat, id, img;
  logic [66:0] exp_q[$];
  int error_cnt = 0, num_checks = 0, seed = 40;
  vfid_reg dut_u (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .cipher_disable_input_in(dis),
    .current_privilege_level_in(lvl), .hyp_enabled_in(hen), .hyp_trap_general_bit_in(tge),
    .hyp_id_group3_trap_bit_in(tid), .streaming_mode_in(sm), .sysreg_req_in(req),
    .sysreg_write_in(wr), .op0_in(enc[15:14]), .op1_in(enc[13:11]), .crn_in(enc[10:7]),
    .crm_in(enc[6:3]), .op2_in(enc[2:0]), .vector_instr_in(vi), .sysreg_ack_out(ack),
    .sysreg_rdata_out(rdat), .sysreg_trap_out(trap), .trap_level_out(tl), .trap_class_out(),
    .vector_instr_legal_out(legal), .vector_feature_id_out(id));
  always #25 sys_clk_in = ~sys_clk_in;
  task automatic check(input logic [66:0] got, input logic [66:0] want);
    num_checks++;
    if (got !== want) begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Reset with the strap held; both features are built in, so only the strap moves the image
  task automatic boot(input logic d);
    @(negedge sys_clk_in);
    rst_in = 1;
    dis = d;
    repeat (6) @(negedge sys_clk_in);
    rst_in = 0;
    repeat (3) @(negedge sys_clk_in);
    img = d ? 64'h0000_1000_0011_0001 : 64'h0000_1101_0011_0021;
    check({3'h0, id}, {3'h0, img});
  endtask
  // One request per cycle; refused ones leave no note
  task automatic acc(input logic [1:0] l, input logic w, input logic [15:0] e);
    @(negedge sys_clk_in);
    lvl = l;
    wr = w;
    enc = e;
    req = 1;
    {hen, tge, tid, sm, vi} = 5'($random(seed));
    if (!w && e == 16'hc024) begin
      if (l == 2'h0) exp_q.push_back({1'b1, (hen && tge) ? 2'h2 : 2'h1, 64'h0});
      else if (l == 2'h1 && hen && tid) exp_q.push_back({3'h6, 64'h0});
      else exp_q.push_back({3'h0, img});
    end
    #1 check({66'h0, legal}, {66'h0, vi});
  endtask
  // Each answer retires the oldest note; an answer with no note is a mismatch
  always @(negedge sys_clk_in) begin
    if (ack || trap) begin
      if (exp_q.size() == 0) check({trap, tl, rdat}, 67'h7);
      else check({trap, trap ? tl : 2'h0, rdat}, exp_q.pop_front());
    end
  end
  initial begin
    for (int d = 0; d < 2; d++) begin
      boot(d[0]);
      repeat (40) acc(2'($random(seed)), 1'b0, 16'hc024);
      acc(2'h3, 1'b1, 16'hc024);
      acc(2'h2, 1'b0, 16'hc025);
      acc(2'h3, 1'b0, 16'hc034);
      acc(2'h2, 1'b0, 16'hc024);
      @(negedge sys_clk_in);
      req = 0;
      repeat (3) @(negedge sys_clk_in);
      check(67'(exp_q.size()), 67'h0);
      check({3'h0, id}, {3'h0, img});
    end
    stop_test();
  end
endmodule
